// file: rtl/dflash_seq.sv
// Data flash command sequencer with AHB-Lite register slave
// Operation
// - Command index selects the command object word that software accesses
// - Index register: only three index bits stored, others read zero
// - ECC result index selects which ECC result word is read
// - Program launch writes supplied words only into unprotected area
// - Index at launch sets word count; index five gives fourth word
// - Complete flag sets again after program and verify finish
// - Program launch with index below two or above five: access error
// - Command unavailable in current mode raises access error
// - Global address outside data flash raises access error
// - Odd global address on a program launch raises access error
// - Word run past data flash end raises access error
// - Program into protected area raises protection violation
// - Verify sets error bit on any error, second on uncorrectable
// - Sector erase erases whole sector, verifies, then sets complete flag
`timescale 1ns/100ps
`default_nettype none
module dflash_seq #(
  parameter int AW = 12,
  parameter logic [22:0] DF_BASE = 23'h100000,
  parameter int SECTOR_WORDS = 128
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output wire logic [31:0] hrdata,
  output wire logic hreadyout,
  output wire logic hresp,
  output wire logic irq
);
  localparam logic [23:0] DF_BYTES = 24'(2 ** (AW + 1));
  localparam logic [AW-1:0] SECT_MASK = AW'(SECTOR_WORDS - 1);
  localparam logic [7:0] SECT_NWORDS = 8'(SECTOR_WORDS);
  localparam logic [23:0] SECT_BYTES = 24'(2 * SECTOR_WORDS);
  localparam int PROG_DONE_MAX = 340;

  typedef struct packed {
    dflash_seq_pkg::seq_state_t state;
    logic [2:0] idx;
    logic [2:0] eidx;
    logic [7:0][15:0] cmd;
    logic ccf;
    logic acc;
    logic pviol;
    logic verr;
    logic vunc;
    logic [3:0] irqs;
    logic [3:0] irqm;
    logic restricted;
    logic prot_en;
    logic [15:0] prot_bnd;
    logic [AW-1:0] base_w;
    logic [7:0] nwords;
    logic [7:0] wcnt;
    logic [11:0] tcnt;
    logic is_erase;
    logic [7:0][15:0] ecc;
    logic logged;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic rdy;
    logic irq;
  } seq_st_t;

  seq_st_t st_r;
  seq_st_t st_nxt;

  // Sticky flag: a set in the clearing cycle wins
  function automatic logic flag_upd(input logic cur, input logic clr,
                                    input logic set);
    return set | (cur & ~clr);
  endfunction : flag_upd

  // More than one bit wrong cannot be corrected by single-bit ECC
  function automatic logic multi_bit(input logic [15:0] d);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, d[i]};
    end
    return n > 5'h01;
  endfunction : multi_bit

  // Word address within the bank for the current step
  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] base,
                                              input logic [7:0] cnt);
    return AW'({{AW{1'b0}}, cnt} + {8'h00, base});
  endfunction : step_addr

  logic [15:0] bank_rdata;
  logic bank_wr;
  logic [AW-1:0] bank_waddr;
  logic [15:0] bank_wdata;

  // Launch decode and parameter checks
  logic wr_dp;
  logic launch;
  logic [22:0] gaddr;
  logic [23:0] off;
  logic [7:0] code;
  logic [7:0] nprog;
  logic [23:0] span_end;
  logic [23:0] sect_off;
  logic in_range;
  logic chk_idx;
  logic chk_mode;
  logic chk_misal;
  logic chk_breach;
  logic is_prog;
  logic is_erase_cmd;
  logic acc_err;
  logic prot_hit;
  logic pv_err;

  always_comb begin
    wr_dp = st_r.ap_wr;
    launch = wr_dp && st_r.ap_addr == dflash_seq_pkg::OFF_STATUS &&
             hwdata[dflash_seq_pkg::ST_COMPLETE] && st_r.ccf &&
             st_r.state == dflash_seq_pkg::S_IDLE;
    gaddr = {st_r.cmd[0][6:0], st_r.cmd[1]};
    code = st_r.cmd[0][15:8];
    off = {1'b0, gaddr} - {1'b0, DF_BASE};
    in_range = gaddr >= DF_BASE && off < DF_BYTES;
    nprog = {5'h00, st_r.idx} - 8'h01;
    span_end = off + {15'h0000, nprog, 1'b0};
    sect_off = {off[23:1] & ~{{(23 - AW){1'b0}}, SECT_MASK}, 1'b0};
    is_prog = code == dflash_seq_pkg::CMD_PROGRAM;
    is_erase_cmd = code == dflash_seq_pkg::CMD_ERASE_SECTOR;
    chk_idx = is_prog && (st_r.idx < dflash_seq_pkg::IDX_PROG_MIN ||
              st_r.idx > dflash_seq_pkg::IDX_PROG_MAX);
    // Restricted mode allows erase only; unknown codes are never available
    chk_mode = (is_prog && st_r.restricted) ||
               (!is_prog && !is_erase_cmd);
    chk_misal = is_prog && gaddr[0];
    chk_breach = is_prog && span_end > DF_BYTES;
    acc_err = chk_idx || chk_mode || !in_range || chk_misal || chk_breach ||
              (is_erase_cmd && st_r.idx != dflash_seq_pkg::IDX_ERASE);
    if (is_prog) begin
      prot_hit = span_end > {8'h00, st_r.prot_bnd};
    end else begin
      prot_hit = sect_off + SECT_BYTES > {8'h00, st_r.prot_bnd};
    end
    pv_err = !acc_err && st_r.prot_en && prot_hit;
  end

  // Register file, bus slave and sequencer
  always_comb begin
    logic [15:0] exp_w;
    logic [15:0] diff;
    logic last;
    logic [3:0] iset;
    logic [3:0] iclr;
    exp_w = 16'h0000;
    diff = 16'h0000;
    iset = 4'h0;
    iclr = 4'h0;
    last = st_r.wcnt == st_r.nwords - 8'h01;
    st_nxt = st_r;
    bank_wr = 1'b0;
    bank_waddr = step_addr(st_r.base_w, st_r.wcnt);
    bank_wdata = st_r.cmd[3'(st_r.wcnt[2:0] + dflash_seq_pkg::IDX_FIRST_DATA)];
    st_nxt.rdy = 1'b1;
    // Data phase of a write; command data is frozen while busy
    if (wr_dp) begin
      case (st_r.ap_addr)
        dflash_seq_pkg::OFF_CMD_INDEX: begin
          if (st_r.state == dflash_seq_pkg::S_IDLE) begin
            st_nxt.idx = hwdata[2:0];
          end
        end
        dflash_seq_pkg::OFF_ECC_INDEX: begin
          st_nxt.eidx = hwdata[2:0];
        end
        dflash_seq_pkg::OFF_CMD_DATA: begin
          if (st_r.state == dflash_seq_pkg::S_IDLE) begin
            st_nxt.cmd[st_r.idx] = hwdata[15:0];
          end
        end
        dflash_seq_pkg::OFF_STATUS: begin
          st_nxt.acc = st_r.acc & ~hwdata[dflash_seq_pkg::ST_ACCESS];
          st_nxt.pviol = st_r.pviol & ~hwdata[dflash_seq_pkg::ST_PROTECT];
        end
        dflash_seq_pkg::OFF_CTRL: begin
          st_nxt.restricted = hwdata[dflash_seq_pkg::CTRL_RESTRICT];
        end
        dflash_seq_pkg::OFF_PROTECT: begin
          st_nxt.prot_en = hwdata[dflash_seq_pkg::PROT_ENABLE];
          st_nxt.prot_bnd = hwdata[15:0];
        end
        dflash_seq_pkg::OFF_IRQ_STATUS: begin
          iclr = hwdata[3:0];
        end
        dflash_seq_pkg::OFF_IRQ_MASK: begin
          st_nxt.irqm = hwdata[3:0];
        end
        default: begin
        end
      endcase
    end
    // Sequencer
    case (st_r.state)
      dflash_seq_pkg::S_IDLE: begin
        if (launch) begin
          st_nxt.verr = 1'b0;
          st_nxt.vunc = 1'b0;
          st_nxt.acc = acc_err;
          st_nxt.pviol = pv_err;
          iset[dflash_seq_pkg::IRQ_ACCESS] = acc_err;
          iset[dflash_seq_pkg::IRQ_PROTECT] = pv_err;
          if (acc_err || pv_err) begin
            st_nxt.ccf = 1'b1;
          end else begin
            st_nxt.ccf = 1'b0;
            st_nxt.wcnt = 8'h00;
            st_nxt.tcnt = 12'h000;
            st_nxt.logged = 1'b0;
            st_nxt.ecc = '0;
            st_nxt.is_erase = is_erase_cmd;
            if (is_erase_cmd) begin
              st_nxt.base_w = off[AW:1] & ~SECT_MASK;
              st_nxt.nwords = SECT_NWORDS;
              st_nxt.state = dflash_seq_pkg::S_EWAIT;
            end else begin
              st_nxt.base_w = off[AW:1];
              st_nxt.nwords = nprog;
              st_nxt.state = dflash_seq_pkg::S_PROG;
            end
          end
        end
      end
      dflash_seq_pkg::S_PROG: begin
        st_nxt.tcnt = st_r.tcnt + 12'h001;
        if (st_r.tcnt == dflash_seq_pkg::PROG_CYC - 12'h001) begin
          bank_wr = 1'b1;
          st_nxt.tcnt = 12'h000;
          st_nxt.wcnt = last ? 8'h00 : st_r.wcnt + 8'h01;
          if (last) begin
            st_nxt.state = dflash_seq_pkg::S_VREAD;
          end
        end
      end
      dflash_seq_pkg::S_EWAIT: begin
        st_nxt.tcnt = st_r.tcnt + 12'h001;
        if (st_r.tcnt == dflash_seq_pkg::ERASE_CYC - 12'h001) begin
          st_nxt.tcnt = 12'h000;
          st_nxt.state = dflash_seq_pkg::S_EWRITE;
        end
      end
      dflash_seq_pkg::S_EWRITE: begin
        // One word per cycle keeps the array to a plain single write port
        bank_wr = 1'b1;
        bank_wdata = dflash_seq_pkg::ERASED_WORD;
        st_nxt.wcnt = last ? 8'h00 : st_r.wcnt + 8'h01;
        if (last) begin
          st_nxt.state = dflash_seq_pkg::S_VREAD;
        end
      end
      dflash_seq_pkg::S_VREAD: begin
        st_nxt.state = dflash_seq_pkg::S_VCMP;
      end
      dflash_seq_pkg::S_VCMP: begin
        exp_w = st_r.is_erase ? dflash_seq_pkg::ERASED_WORD : bank_wdata;
        diff = bank_rdata ^ exp_w;
        if (diff != 16'h0000) begin
          st_nxt.verr = 1'b1;
          st_nxt.vunc = st_r.vunc | multi_bit(diff);
          iset[dflash_seq_pkg::IRQ_VERIFY] = 1'b1;
          st_nxt.ecc[4] = st_r.ecc[4] + 16'h0001;
          if (!st_r.logged) begin
            st_nxt.logged = 1'b1;
            st_nxt.ecc[0] = 16'(step_addr(st_r.base_w, st_r.wcnt));
            st_nxt.ecc[1] = bank_rdata;
            st_nxt.ecc[2] = exp_w;
            st_nxt.ecc[3] = diff;
          end
        end
        if (last) begin
          st_nxt.ccf = 1'b1;
          iset[dflash_seq_pkg::IRQ_DONE] = 1'b1;
          st_nxt.state = dflash_seq_pkg::S_IDLE;
        end else begin
          st_nxt.wcnt = st_r.wcnt + 8'h01;
          st_nxt.state = dflash_seq_pkg::S_VREAD;
        end
      end
      default: begin
        st_nxt.state = dflash_seq_pkg::S_IDLE;
      end
    endcase
    // Interrupt flags
    for (int i = 0; i < 4; i++) begin
      st_nxt.irqs[i] = flag_upd(st_r.irqs[i], iclr[i], iset[i]);
    end
    st_nxt.irq = |(st_nxt.irqs & st_nxt.irqm);
    // Address phase; read data is latched here so it stands in the data phase
    st_nxt.ap_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      st_nxt.ap_wr = hwrite;
      st_nxt.ap_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          dflash_seq_pkg::OFF_CMD_INDEX: st_nxt.hrdata = {29'h0, st_r.idx};
          dflash_seq_pkg::OFF_ECC_INDEX: st_nxt.hrdata = {29'h0, st_r.eidx};
          dflash_seq_pkg::OFF_CMD_DATA:
            st_nxt.hrdata = {16'h0000, st_r.cmd[st_r.idx]};
          dflash_seq_pkg::OFF_STATUS:
            st_nxt.hrdata = {24'h000000, st_r.ccf, 1'b0, st_r.acc, st_r.pviol,
                             2'b00, st_r.verr, st_r.vunc};
          dflash_seq_pkg::OFF_ECC_DATA:
            st_nxt.hrdata = {16'h0000, st_r.ecc[st_r.eidx]};
          dflash_seq_pkg::OFF_CTRL: st_nxt.hrdata = {31'h0, st_r.restricted};
          dflash_seq_pkg::OFF_PROTECT:
            st_nxt.hrdata = {15'h0000, st_r.prot_en, st_r.prot_bnd};
          dflash_seq_pkg::OFF_IRQ_STATUS: st_nxt.hrdata = {28'h0, st_r.irqs};
          dflash_seq_pkg::OFF_IRQ_MASK: st_nxt.hrdata = {28'h0, st_r.irqm};
          default: st_nxt.hrdata = 32'h00000000;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.state <= dflash_seq_pkg::S_IDLE;
      st_r.ccf <= 1'b1;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  dflash_bank #(.AW(AW)) u_bank (
    .ref_clk(ref_clk),
    .wr_en(bank_wr),
    .wr_addr(bank_waddr),
    .wr_data(bank_wdata),
    .rd_addr(step_addr(st_r.base_w, st_r.wcnt)),
    .rd_data(bank_rdata)
  );

  assign hrdata = st_r.hrdata;
  assign hreadyout = st_r.rdy;
  assign hresp = 1'b0;
  assign irq = st_r.irq;

  // Checks
  property p_idx_read;
    @(posedge ref_clk) disable iff (!reset_n)
    (hsel && hready && htrans[1] && !hwrite &&
     haddr[7:0] == dflash_seq_pkg::OFF_CMD_INDEX)
    |=> hrdata[31:3] == 29'h0 && hrdata[2:0] == $past(st_r.idx);
  endproperty
  a_idx_read: assert property (p_idx_read)
    else $error("index read shows stray bits");

  property p_data_write;
    @(posedge ref_clk) disable iff (!reset_n)
    (wr_dp && st_r.ap_addr == dflash_seq_pkg::OFF_CMD_DATA &&
     st_r.state == dflash_seq_pkg::S_IDLE)
    |=> st_r.cmd[$past(st_r.idx)] == $past(hwdata[15:0]);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("command word not stored at index");

  property p_ecc_read;
    @(posedge ref_clk) disable iff (!reset_n)
    (hsel && hready && htrans[1] && !hwrite &&
     haddr[7:0] == dflash_seq_pkg::OFF_ECC_DATA)
    |=> hrdata == {16'h0000, $past(st_r.ecc[st_r.eidx])};
  endproperty
  a_ecc_read: assert property (p_ecc_read)
    else $error("ECC result word mismatch");

  property p_bad_idx;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && chk_idx |=> st_r.acc && st_r.ccf &&
                          st_r.state == dflash_seq_pkg::S_IDLE;
  endproperty
  a_bad_idx: assert property (p_bad_idx)
    else $error("bad index launch not flagged");

  property p_mode;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && chk_mode |=> st_r.acc;
  endproperty
  a_mode: assert property (p_mode)
    else $error("unavailable command not flagged");

  property p_range;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && !in_range |=> st_r.acc;
  endproperty
  a_range: assert property (p_range)
    else $error("invalid address not flagged");

  property p_misal;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && chk_misal |=> st_r.acc;
  endproperty
  a_misal: assert property (p_misal)
    else $error("odd address not flagged");

  property p_breach;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && chk_breach |=> st_r.acc;
  endproperty
  a_breach: assert property (p_breach)
    else $error("run past end not flagged");

  property p_prot;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && pv_err |=> st_r.pviol && st_r.ccf && !bank_wr
                         [*2];
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected launch not refused");

  property p_no_write_err;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && (acc_err || pv_err) |=>
      st_r.state == dflash_seq_pkg::S_IDLE && st_r.ccf;
  endproperty
  a_no_write_err: assert property (p_no_write_err)
    else $error("faulty launch started work");

  property p_prog_run;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && is_prog && !acc_err && !pv_err |=>
      !st_r.ccf && st_r.nwords == {5'h00, $past(st_r.idx)} - 8'h01
      ##[1:PROG_DONE_MAX] st_r.ccf;
  endproperty
  a_prog_run: assert property (p_prog_run)
    else $error("program word count or completion wrong");

  // Word the verify step expects at the current step
  logic [15:0] exp_chk;
  assign exp_chk = st_r.is_erase ? dflash_seq_pkg::ERASED_WORD :
    st_r.cmd[3'(st_r.wcnt[2:0] + dflash_seq_pkg::IDX_FIRST_DATA)];

  property p_verify;
    @(posedge ref_clk) disable iff (!reset_n)
    st_r.state == dflash_seq_pkg::S_VCMP && bank_rdata != exp_chk
    |=> st_r.verr;
  endproperty
  a_verify: assert property (p_verify)
    else $error("verify mismatch not flagged");

  property p_done;
    @(posedge ref_clk) disable iff (!reset_n)
    st_r.state == dflash_seq_pkg::S_VCMP &&
    st_r.wcnt == st_r.nwords - 8'h01
    |=> st_r.ccf && st_r.state == dflash_seq_pkg::S_IDLE;
  endproperty
  a_done: assert property (p_done)
    else $error("complete flag not set at end");

  property p_erase;
    @(posedge ref_clk) disable iff (!reset_n)
    launch && is_erase_cmd && !acc_err && !pv_err |=>
      st_r.state == dflash_seq_pkg::S_EWAIT && st_r.nwords == SECT_NWORDS;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase launch did not start");

  // Last step of a run, for the covers
  logic last_chk;
  assign last_chk = st_r.wcnt == st_r.nwords - 8'h01;

  c_prog_ok: cover property (@(posedge ref_clk) disable iff (!reset_n)
    launch && is_prog && !acc_err && !pv_err);
  c_erase_done: cover property (@(posedge ref_clk) disable iff (!reset_n)
    st_r.is_erase && st_r.state == dflash_seq_pkg::S_VCMP && last_chk);
  c_acc_err: cover property (@(posedge ref_clk) disable iff (!reset_n)
    launch && acc_err);
endmodule : dflash_seq
`default_nettype wire

// file: rtl/dflash_seq_pkg.sv
// Package of offsets, fields, codes, timing and states for the data flash sequencer
`default_nettype none
package dflash_seq_pkg;
  // Register indices and their byte addresses on the word-wide bus
  localparam logic [7:0] REG_IDX_CMD_INDEX = 8'h02;
  localparam logic [7:0] REG_IDX_ECC_INDEX = 8'h03;
  localparam logic [7:0] OFF_CMD_INDEX = {REG_IDX_CMD_INDEX[5:0], 2'b00};
  localparam logic [7:0] OFF_ECC_INDEX = {REG_IDX_ECC_INDEX[5:0], 2'b00};
  localparam logic [7:0] OFF_CMD_DATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_ECC_DATA = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_PROTECT = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  // Flash status register bit positions
  localparam int ST_COMPLETE = 7;
  localparam int ST_ACCESS = 5;
  localparam int ST_PROTECT = 4;
  localparam int ST_VERIFY = 1;
  localparam int ST_UNCORR = 0;
  // Interrupt status and mask bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACCESS = 1;
  localparam int IRQ_PROTECT = 2;
  localparam int IRQ_VERIFY = 3;
  // Control and protection fields
  localparam int CTRL_RESTRICT = 0;
  localparam int PROT_ENABLE = 16;
  // Command codes and command object indices
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  localparam logic [2:0] IDX_PROG_MIN = 3'h2;
  localparam logic [2:0] IDX_PROG_MAX = 3'h5;
  localparam logic [2:0] IDX_ERASE = 3'h1;
  localparam logic [2:0] IDX_FIRST_DATA = 3'h2;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Timing: figures in ns, cycle counts derived at the clock rate
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_NS = 2000;
  localparam int ERASE_TIME_NS = 100000;
  localparam int PROG_CYC_I = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC_I =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] PROG_CYC = 12'(PROG_CYC_I);
  localparam logic [11:0] ERASE_CYC = 12'(ERASE_CYC_I);
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_PROG = 6'h02,
    S_EWAIT = 6'h04,
    S_EWRITE = 6'h08,
    S_VREAD = 6'h10,
    S_VCMP = 6'h20
  } seq_state_t;
endpackage : dflash_seq_pkg
`default_nettype wire

// file: rtl/dflash_bank.sv
// Data flash word array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module dflash_bank #(
  parameter int AW = 12
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output wire logic [15:0] rd_data
);
  typedef struct packed {
    logic [15:0] rd_data;
  } bank_st_t;

  // Cells hold no reset value, like real flash before its first erase
  logic [15:0] mem [0:(2**AW)-1];
  bank_st_t st_r;
  bank_st_t st_nxt;

  // Read latch
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_data = mem[rd_addr];
  end

  // Storage and read register
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    st_r <= st_nxt;
  end

  assign rd_data = st_r.rd_data;
endmodule : dflash_bank
`default_nettype wire

// file: tb/dflash_seq_tb_top.sv
// Self-checking bench for the data flash command sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module dflash_seq_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic irq;
  int err_count = 0;
  int compares = 0;
  int seed = 92;
  int cyc = 0;
  int t0 = 0;
  logic [31:0] q;
  logic [31:0] r;
  logic [15:0] d [8];
  logic [22:0] ga;
  // Bad launches: short index, long index, odd, outside, past the end
  logic [22:0] ea [5] = '{23'h100000, 23'h100000, 23'h100001, 23'h000000,
    23'h101FFA};
  logic [2:0] en [5] = '{3'h1, 3'h6, 3'h2, 3'h2, 3'h5};

  dflash_seq dflash_seq_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

  // Bus clock, 25 ns period
  always #12.5 ref_clk = ~ref_clk;
  // Cycle count for timing of operations
  always @(posedge ref_clk) cyc <= cyc + 1;

  // One single-word AHB transfer; read data lands in q
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] v);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic chk_rd(input string n, input logic [7:0] a,
    input logic [31:0] e);
    xfer(a, 1'b0, 32'h00000000);
    `CHK(n, e, q)
    // The slave never signals an error response
    `CHK("hresp", 1'b0, hresp)
  endtask : chk_rd

  // Write one command word through the index register
  task automatic wcmd(input logic [2:0] i, input logic [15:0] v);
    xfer(dflash_seq_pkg::OFF_CMD_INDEX, 1'b1, {29'h0, i});
    xfer(dflash_seq_pkg::OFF_CMD_DATA, 1'b1, {16'h0000, v});
  endtask : wcmd

  task automatic launch(input logic [7:0] c, input logic [22:0] a,
    input logic [2:0] n);
    wcmd(3'h0, {c, 1'b0, a[22:16]});
    wcmd(3'h1, a[15:0]);
    for (int i = 2; i <= int'(n) && i < 6; i++) begin
      wcmd(3'(i), 16'($random(seed)));
    end
    xfer(dflash_seq_pkg::OFF_CMD_INDEX, 1'b1, {29'h0, n});
    xfer(dflash_seq_pkg::OFF_STATUS, 1'b1, 32'h00000080);
    t0 = cyc;
  endtask : launch

  // Poll status until complete; bounded so a stuck flag cannot hang
  task automatic wait_done;
    q = 32'h00000000;
    for (int i = 0; i < 3000 && q[7] !== 1'b1; i++)
      xfer(dflash_seq_pkg::OFF_STATUS, 1'b0, 32'h00000000);
  endtask : wait_done

  function automatic logic [31:0] exp_st(input logic acc, input logic prot);
    exp_st = 32'h00000080;
    exp_st[dflash_seq_pkg::ST_ACCESS] = acc;
    exp_st[dflash_seq_pkg::ST_PROTECT] = prot;
  endfunction : exp_st

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Watchdog sized well above the erase time
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk_rd("status_rst", dflash_seq_pkg::OFF_STATUS, exp_st(0, 0));
    chk_rd("index_rst", dflash_seq_pkg::OFF_CMD_INDEX, 32'h0);
    chk_rd("unmapped", 8'h30, 32'h00000000);
    // Fill every word, then read back to prove the index selects
    for (int i = 0; i < 8; i++) begin
      d[i] = 16'($random(seed));
      wcmd(3'(i), d[i]);
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      xfer(dflash_seq_pkg::OFF_CMD_INDEX, 1'b1, {r[31:3], 3'(i)});
      chk_rd("index", dflash_seq_pkg::OFF_CMD_INDEX, 32'(i));
      chk_rd("cmd_word", dflash_seq_pkg::OFF_CMD_DATA, {16'h0, d[i]});
      xfer(dflash_seq_pkg::OFF_ECC_INDEX, 1'b1, r);
      chk_rd("ecc_idx", dflash_seq_pkg::OFF_ECC_INDEX, 32'(r[2:0]));
    end
    // Refused launches leave complete set and flag an access error
    for (int i = 0; i < 5; i++) begin
      launch(dflash_seq_pkg::CMD_PROGRAM, ea[i], en[i]);
      chk_rd("bad_launch", dflash_seq_pkg::OFF_STATUS,
        exp_st(1, 0));
    end
    xfer(dflash_seq_pkg::OFF_CTRL, 1'b1, 32'h00000001);
    launch(dflash_seq_pkg::CMD_PROGRAM, 23'h100000, 3'h2);
    chk_rd("restricted", dflash_seq_pkg::OFF_STATUS, exp_st(1, 0));
    xfer(dflash_seq_pkg::OFF_CTRL, 1'b1, 32'h00000000);
    // Good programs of one and four words; duration scales with count
    for (int n = 2; n <= 5; n += 3) begin
      r = $random(seed);
      ga = 23'h100000 | {12'h000, r[10:1], 1'b0};
      launch(dflash_seq_pkg::CMD_PROGRAM, ga, 3'(n));
      xfer(dflash_seq_pkg::OFF_CMD_INDEX, 1'b1, 32'h00000003);
      chk_rd("busy_idx", dflash_seq_pkg::OFF_CMD_INDEX, 32'(n));
      wait_done();
      `CHK("prog_st", exp_st(0, 0), q)
      r = 32'(cyc - t0);
      `CHK("prog_min", 1'b1, r >= 32'(80 * (n - 1)))
      `CHK("prog_max", 1'b1, r < 32'(90 * (n - 1) + 20))
      // A clean verify leaves the error count at zero
      xfer(dflash_seq_pkg::OFF_ECC_INDEX, 1'b1, 32'h00000004);
      chk_rd("ecc_cnt", dflash_seq_pkg::OFF_ECC_DATA, 32'h0);
    end
    // Protected target; interrupt masked, unmasked, then cleared
    xfer(dflash_seq_pkg::OFF_IRQ_MASK, 1'b1, 32'h00000000);
    xfer(dflash_seq_pkg::OFF_PROTECT, 1'b1, 32'h00010000);
    launch(dflash_seq_pkg::CMD_PROGRAM, ga, 3'h2);
    chk_rd("prot_st", dflash_seq_pkg::OFF_STATUS,
      exp_st(0, 1));
    `CHK("irq_masked", 1'b0, irq)
    xfer(dflash_seq_pkg::OFF_IRQ_MASK, 1'b1, 32'h00000004);
    repeat (2) @(posedge ref_clk);
    `CHK("irq_on", 1'b1, irq)
    xfer(dflash_seq_pkg::OFF_IRQ_STATUS, 1'b1, 32'h0000000F);
    repeat (2) @(posedge ref_clk);
    `CHK("irq_off", 1'b0, irq)
    chk_rd("irq_clr", dflash_seq_pkg::OFF_IRQ_STATUS, 32'h00000000);
    xfer(dflash_seq_pkg::OFF_PROTECT, 1'b1, 32'h00000000);
    // Sector erase runs the long wait, writes and verify
    launch(dflash_seq_pkg::CMD_ERASE_SECTOR, ga, 3'h1);
    wait_done();
    `CHK("erase_st", exp_st(0, 0), q)
    `CHK("erase_len", 1'b1, cyc - t0 > 4000)
    end_of_test();
  end
endmodule : dflash_seq_tb_top
`default_nettype wire
